// file: flash_port_pkg.sv
// Shared constants and state types for the flash LPC and multiplexed port ends.
`default_nettype none
package flash_port_pkg;
  // LPC nibble values.
  localparam logic [3:0] NIB_START = 4'h0;
  localparam logic [3:0] NIB_TAR = 4'hf;
  localparam logic [3:0] NIB_SYNC_OK = 4'h0;
  localparam logic [3:0] CYCTYPE_MEM_WRITE = 4'h6;
  localparam logic [1:0] CYCTYPE_FIELD = 2'h1;
  localparam int CYCTYPE_HI = 3;
  localparam int CYCTYPE_LO = 2;
  localparam int CYCTYPE_DIR = 1;
  // Address phase layout.
  localparam int ADDR_NIBBLES = 8;
  localparam logic [2:0] ADDR_LAST_NIB = 3'h7;
  localparam int ADDR_TOP_MSB = 31;
  localparam int ADDR_TOP_LSB = 26;
  localparam logic [5:0] ADDR_TOP_ONES = 6'h3f;
  localparam int ADDR_ARRAY_BIT = 22;
  // Multiplexed port layout: row is the low part, column the high part.
  localparam int MUX_ADDR_W = 11;
  localparam int MUX_COL_W = 10;
  localparam int MUX_FULL_W = 21;
  localparam int SIG_ADDR_MSB = 20;
  localparam int SIG_SEL_BIT = 0;
  // Timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_PULSE_MIN_NS = 100;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABORT_TIME_MAX_NS = 30000;
  localparam int ABORT_TIME_MAX_CYC = ABORT_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_TIMEOUT_CYC = 8;
  localparam int MUX_READ_CYC = 3;
  // Mux operations requested by the programmer's user side.
  localparam logic [1:0] MUX_OP_READ = 2'h0;
  localparam logic [1:0] MUX_OP_WRITE = 2'h1;
  localparam logic [1:0] MUX_OP_RESET = 2'h2;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0, L_CYC = 3'h1, L_ADDR = 3'h2, L_DATA = 3'h3,
    L_TAR_IN = 3'h4, L_TAR_TAKE = 3'h5, L_SYNC = 3'h6, L_TAR_OUT = 3'h7
  } lpc_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_CYC = 3'h1, H_ADDR = 3'h2, H_DATA = 3'h3,
    H_TAR = 3'h4, H_RELEASE = 3'h5, H_WAIT_SYNC = 3'h6, H_END = 3'h7
  } lpc_host_state_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h0, M_ROW = 4'h1, M_RC_HI = 4'h2, M_COL = 4'h3, M_RC_LO = 4'h4,
    M_WLOW = 4'h5, M_WHIGH = 4'h6, M_READ = 4'h7, M_RESET = 4'h8, M_END = 4'h9
  } mux_host_state_t;
endpackage
`default_nettype wire

// file: flash_port_if.sv
// Pin-level carrier joining the programmer or host end to the flash device end.
`default_nettype none
interface flash_port_if;
  // LPC pins, per-party drive and the resolved level with pull-ups.
  logic lframe_n;
  logic [3:0] lad_h;
  logic lad_h_oe;
  logic [3:0] lad_d;
  logic lad_d_oe;
  logic [3:0] lad;
  // Multiplexed port pins.
  logic mux_mode;
  logic [10:0] mux_address_inputs;
  logic row_column_select;
  logic write_enable_n;
  logic output_enable_n;
  logic interface_reset_n;
  logic [7:0] dq_h;
  logic dq_h_oe;
  logic [7:0] dq_d;
  logic dq_d_oe;
  logic [7:0] data_pins;

  // Undriven lines float high through the board pull-ups.
  assign lad = lad_d_oe ? lad_d : (lad_h_oe ? lad_h : 4'hf);
  assign data_pins = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'hff);

  modport dev (
    input lframe_n, lad, mux_mode, mux_address_inputs, row_column_select,
    input write_enable_n, output_enable_n, interface_reset_n, data_pins,
    output lad_d, lad_d_oe, dq_d, dq_d_oe
  );
  modport host (
    output lframe_n, lad_h, lad_h_oe, mux_mode, mux_address_inputs, row_column_select,
    output write_enable_n, output_enable_n, interface_reset_n, dq_h, dq_h_oe,
    input lad, data_pins
  );
endinterface
`default_nettype wire

// file: flash_port_device.sv
// Flash device end: LPC single-byte write target and multiplexed programming port.
// Operation
// - Frame low with 0000b starts cycle one.
// - Cycle type 011Xb marks write; bit0 ignored.
// - Eight address nibbles, MSB first, top ones.
// - Data byte arrives low nibble first.
// - Host drives 1111b first turnaround.
// - Second turnaround floats; device takes over.
// - Device drives SYNC 0000b in cycle fifteen.
// - Device drives 1111b in cycle sixteen.
// - Device floats LAD in cycle seventeen.
// - Mux port: all blocks unprotected always.
// - Mux port: commands only, no extras.
// - Mux read: latch address, OE low drives.
// - Mux write: data captured on WE rise.
// - OE high keeps data pins floating.
// - Interface reset low forces reset mode.
// - Reset during program/erase aborts operation.
// - Signature: A0 selects maker or device code.
// - Frame low mid-transfer abandons, releases LAD.
// - Frame high idle keeps LAD floating.
`default_nettype none
module flash_port_device
  #(
    parameter logic [7:0] MANUF_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] DEVICE_CODE = 8'ha5 // Arbitrary value.
  )
  (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Pins.
    flash_port_if.dev BUS,
    // Array and controller side.
    input wire logic BUSY,
    input wire logic SIG_MODE,
    input wire logic [7:0] RD_DATA,
    output logic [flash_port_pkg::MUX_FULL_W-1:0] RD_ADDR,
    // Received command bytes.
    output logic CMD_VALID,
    output logic [31:0] CMD_ADDR,
    output logic [7:0] CMD_DATA,
    output logic CMD_ARRAY,
    output logic CMD_VIA_MUX,
    // Mode and status.
    output logic IN_RESET,
    output logic ABORT_OP,
    output logic PROTECT_ALLOWED,
    output logic EXTRA_REGS_ALLOWED
  );
  import flash_port_pkg::*;

  lpc_dev_state_t state;
  logic [2:0] cnt;
  logic [31:0] addr_shift;
  logic [3:0] data_lo;
  logic [MUX_ADDR_W-1:0] row_latch;
  logic [MUX_COL_W-1:0] col_latch;
  logic rc_q;
  logic we_q;
  logic reset_q;
  logic in_rst;
  logic lpc_fire;
  logic mux_fire;
  logic [MUX_FULL_W-1:0] full_addr;

  // Start field decode, used both from idle and when a new frame cuts in.
  function automatic logic is_start(input logic frame_n, input logic [3:0] nib);
    is_start = !frame_n && (nib == NIB_START);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset mode and mode-dependent features.

  // Interface reset wins over every strobe, so nothing below needs to look at it twice.
  assign in_rst = RST || !BUS.interface_reset_n;
  assign full_addr = {col_latch, row_latch};

  // Mode outputs are registered so they are clean from reset onward.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      IN_RESET <= 1'b1;
      PROTECT_ALLOWED <= 1'b0;
      EXTRA_REGS_ALLOWED <= 1'b0;
      reset_q <= 1'b1;
      ABORT_OP <= 1'b0;
    end
    else
    begin
      IN_RESET <= in_rst;
      PROTECT_ALLOWED <= !BUS.mux_mode;
      EXTRA_REGS_ALLOWED <= !BUS.mux_mode;
      reset_q <= BUS.interface_reset_n;
      // The abort is flagged on the first edge after the fall, well inside the limit.
      ABORT_OP <= reset_q && !BUS.interface_reset_n && BUSY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LPC write cycle.

  // The byte is handed on as soon as its second nibble lands, before the turnaround.
  assign lpc_fire = (state == L_DATA) && (cnt != 3'h0) && BUS.lframe_n
                    && (addr_shift[ADDR_TOP_MSB:ADDR_TOP_LSB] == ADDR_TOP_ONES);

  // One process owns the LPC sequence and the LAD drivers.
  always_ff @(posedge CLK)
  begin
    if (in_rst || BUS.mux_mode)
    begin
      state <= L_IDLE;
      cnt <= 3'h0;
      addr_shift <= 32'h0;
      data_lo <= 4'h0;
      BUS.lad_d <= NIB_TAR;
      BUS.lad_d_oe <= 1'b0;
    end
    else if (state != L_IDLE && !BUS.lframe_n)
    begin
      // A new frame abandons the transfer; a start nibble restarts at once.
      BUS.lad_d_oe <= 1'b0;
      cnt <= 3'h0;
      state <= is_start(BUS.lframe_n, BUS.lad) ? L_CYC : L_IDLE;
    end
    else
    begin
      case (state)
        L_IDLE:
        begin
          BUS.lad_d_oe <= 1'b0;
          if (is_start(BUS.lframe_n, BUS.lad))
          begin
            state <= L_CYC;
          end
        end
        L_CYC:
        begin
          cnt <= 3'h0;
          if (BUS.lad[CYCTYPE_HI:CYCTYPE_LO] == CYCTYPE_FIELD && BUS.lad[CYCTYPE_DIR])
          begin
            state <= L_ADDR;
          end
          else
          begin
            state <= L_IDLE;
          end
        end
        L_ADDR:
        begin
          addr_shift <= {addr_shift[27:0], BUS.lad};
          cnt <= cnt + 3'h1;
          if (cnt == ADDR_LAST_NIB)
          begin
            cnt <= 3'h0;
            state <= L_DATA;
          end
        end
        L_DATA:
        begin
          if (cnt == 3'h0)
          begin
            data_lo <= BUS.lad;
            cnt <= 3'h1;
          end
          else
          begin
            cnt <= 3'h0;
            state <= lpc_fire ? L_TAR_IN : L_IDLE;
          end
        end
        L_TAR_IN:
        begin
          // The host owns this cycle with 1111b; nothing is driven here.
          state <= L_TAR_TAKE;
        end
        L_TAR_TAKE:
        begin
          // Lines float this cycle; SYNC goes out on the next.
          BUS.lad_d <= NIB_SYNC_OK;
          BUS.lad_d_oe <= 1'b1;
          state <= L_SYNC;
        end
        L_SYNC:
        begin
          BUS.lad_d <= NIB_TAR;
          state <= L_TAR_OUT;
        end
        L_TAR_OUT:
        begin
          BUS.lad_d_oe <= 1'b0;
          state <= L_IDLE;
        end
        default:
        begin
          state <= L_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplexed programming port.

  // Strobes are sampled each clock; edges are seen against the previous sample.
  assign mux_fire = BUS.mux_mode && !we_q && BUS.write_enable_n && BUS.output_enable_n;

  // Row latched as select rises, column as it falls.
  always_ff @(posedge CLK)
  begin
    if (in_rst)
    begin
      rc_q <= 1'b0;
      we_q <= 1'b1;
      row_latch <= '0;
      col_latch <= '0;
      RD_ADDR <= '0;
    end
    else
    begin
      rc_q <= BUS.row_column_select;
      we_q <= BUS.write_enable_n;
      if (BUS.mux_mode && !rc_q && BUS.row_column_select)
      begin
        row_latch <= BUS.mux_address_inputs;
      end
      if (BUS.mux_mode && rc_q && !BUS.row_column_select)
      begin
        col_latch <= BUS.mux_address_inputs[MUX_COL_W-1:0];
      end
      RD_ADDR <= full_addr;
    end
  end

  // Data pins drive only for a true read; in signature mode, addresses 0 and 1 return the signature codes.
  always_ff @(posedge CLK)
  begin
    if (in_rst)
    begin
      BUS.dq_d <= 8'h00;
      BUS.dq_d_oe <= 1'b0;
    end
    else
    begin
      BUS.dq_d_oe <= BUS.mux_mode && !BUS.output_enable_n && BUS.write_enable_n;
      if (SIG_MODE && full_addr[SIG_ADDR_MSB:1] == '0)
      begin
        BUS.dq_d <= full_addr[SIG_SEL_BIT] ? DEVICE_CODE : MANUF_CODE;
      end
      else
      begin
        BUS.dq_d <= RD_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command hand-off, shared by both ports; mux writes always target the array, and LPC wins a tie.

  always_ff @(posedge CLK)
  begin
    if (in_rst)
    begin
      CMD_VALID <= 1'b0;
      CMD_ADDR <= 32'h0;
      CMD_DATA <= 8'h00;
      CMD_ARRAY <= 1'b0;
      CMD_VIA_MUX <= 1'b0;
    end
    else
    begin
      CMD_VALID <= lpc_fire || mux_fire;
      if (lpc_fire)
      begin
        CMD_ADDR <= addr_shift;
        CMD_DATA <= {BUS.lad, data_lo};
        CMD_ARRAY <= addr_shift[ADDR_ARRAY_BIT];
        CMD_VIA_MUX <= 1'b0;
      end
      else if (mux_fire)
      begin
        CMD_ADDR <= {{(32 - MUX_FULL_W){1'b0}}, full_addr};
        CMD_DATA <= BUS.data_pins;
        CMD_ARRAY <= 1'b1;
        CMD_VIA_MUX <= 1'b1;
      end
    end
  end
endmodule // flash_port_device
`default_nettype wire

// file: flash_port_host.sv
// Host and programmer end: LPC write master and multiplexed port sequencer.
`default_nettype none
module flash_port_host
  (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Pins.
    flash_port_if.host BUS,
    // Port selection.
    input wire logic MUX_MODE,
    // LPC write requests.
    input wire logic LPC_REQ,
    input wire logic [31:0] LPC_ADDR,
    input wire logic [7:0] LPC_DATA,
    output logic LPC_READY,
    output logic LPC_DONE,
    output logic LPC_SYNC_OK,
    // Multiplexed port requests.
    input wire logic MUX_REQ,
    input wire logic [1:0] MUX_OP,
    input wire logic [flash_port_pkg::MUX_FULL_W-1:0] MUX_ADDR,
    input wire logic [7:0] MUX_WDATA,
    output logic MUX_READY,
    output logic MUX_DONE,
    output logic [7:0] MUX_RDATA
  );
  import flash_port_pkg::*;

  lpc_host_state_t hstate;
  mux_host_state_t mstate;
  logic [3:0] hcnt;
  logic [3:0] mcnt;
  logic [31:0] a_q;
  logic [7:0] d_q;
  logic [1:0] op_q;
  logic [MUX_FULL_W-1:0] ma_q;

  ////////////////////////////////////////////////////////////////////////////
  // LPC write master.

  // Every field is registered a cycle ahead of the edge that samples it.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      hstate <= H_IDLE;
      hcnt <= 4'h0;
      a_q <= 32'h0;
      d_q <= 8'h00;
      BUS.lframe_n <= 1'b1;
      BUS.lad_h <= NIB_TAR;
      BUS.lad_h_oe <= 1'b0;
      LPC_READY <= 1'b0;
      LPC_DONE <= 1'b0;
      LPC_SYNC_OK <= 1'b0;
    end
    else
    begin
      LPC_DONE <= 1'b0;
      case (hstate)
        H_IDLE:
        begin
          LPC_READY <= !MUX_MODE;
          if (LPC_REQ && LPC_READY && !MUX_MODE)
          begin
            a_q <= LPC_ADDR;
            d_q <= LPC_DATA;
            BUS.lframe_n <= 1'b0;
            BUS.lad_h <= NIB_START;
            BUS.lad_h_oe <= 1'b1;
            LPC_READY <= 1'b0;
            hstate <= H_CYC;
          end
        end
        H_CYC:
        begin
          BUS.lframe_n <= 1'b1;
          BUS.lad_h <= CYCTYPE_MEM_WRITE;
          hcnt <= 4'h0;
          hstate <= H_ADDR;
        end
        H_ADDR:
        begin
          BUS.lad_h <= a_q[31:28];
          a_q <= {a_q[27:0], 4'h0};
          hcnt <= hcnt + 4'h1;
          if (hcnt == 4'(ADDR_NIBBLES - 1))
          begin
            hcnt <= 4'h0;
            hstate <= H_DATA;
          end
        end
        H_DATA:
        begin
          BUS.lad_h <= (hcnt == 4'h0) ? d_q[3:0] : d_q[7:4];
          hcnt <= hcnt + 4'h1;
          if (hcnt != 4'h0)
          begin
            hstate <= H_TAR;
          end
        end
        H_TAR:
        begin
          BUS.lad_h <= NIB_TAR;
          hstate <= H_RELEASE;
        end
        H_RELEASE:
        begin
          BUS.lad_h_oe <= 1'b0;
          hcnt <= 4'h0;
          hstate <= H_WAIT_SYNC;
        end
        H_WAIT_SYNC:
        begin
          // Bounded wait so a missing device cannot hang the master.
          hcnt <= hcnt + 4'h1;
          LPC_SYNC_OK <= (BUS.lad == NIB_SYNC_OK);
          if (BUS.lad == NIB_SYNC_OK || hcnt == 4'(SYNC_TIMEOUT_CYC))
          begin
            hstate <= H_END;
          end
        end
        H_END:
        begin
          // Device turnaround cycle; the bus is ours again after it floats.
          LPC_DONE <= 1'b1;
          hstate <= H_IDLE;
        end
        default:
        begin
          hstate <= H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplexed port sequencer.

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mstate <= M_IDLE;
      mcnt <= 4'h0;
      op_q <= MUX_OP_READ;
      ma_q <= '0;
      BUS.mux_mode <= 1'b0;
      BUS.mux_address_inputs <= '0;
      BUS.row_column_select <= 1'b0;
      BUS.write_enable_n <= 1'b1;
      BUS.output_enable_n <= 1'b1;
      BUS.interface_reset_n <= 1'b1;
      BUS.dq_h <= 8'h00;
      BUS.dq_h_oe <= 1'b0;
      MUX_READY <= 1'b0;
      MUX_DONE <= 1'b0;
      MUX_RDATA <= 8'h00;
    end
    else
    begin
      BUS.mux_mode <= MUX_MODE;
      MUX_DONE <= 1'b0;
      case (mstate)
        M_IDLE:
        begin
          MUX_READY <= MUX_MODE;
          mcnt <= 4'h0;
          if (MUX_REQ && MUX_READY && MUX_MODE)
          begin
            op_q <= MUX_OP;
            ma_q <= MUX_ADDR;
            BUS.dq_h <= MUX_WDATA;
            MUX_READY <= 1'b0;
            mstate <= (MUX_OP == MUX_OP_RESET) ? M_RESET : M_ROW;
          end
        end
        M_ROW:
        begin
          BUS.mux_address_inputs <= ma_q[MUX_ADDR_W-1:0];
          BUS.row_column_select <= 1'b0;
          mstate <= M_RC_HI;
        end
        M_RC_HI:
        begin
          BUS.row_column_select <= 1'b1;
          mstate <= M_COL;
        end
        M_COL:
        begin
          BUS.mux_address_inputs <= {1'b0, ma_q[MUX_FULL_W-1:MUX_ADDR_W]};
          mstate <= M_RC_LO;
        end
        M_RC_LO:
        begin
          BUS.row_column_select <= 1'b0;
          mstate <= (op_q == MUX_OP_WRITE) ? M_WLOW : M_READ;
        end
        M_WLOW:
        begin
          BUS.dq_h_oe <= 1'b1;
          BUS.write_enable_n <= 1'b0;
          mstate <= M_WHIGH;
        end
        M_WHIGH:
        begin
          // Data stays driven through the rising edge of the write strobe.
          BUS.write_enable_n <= 1'b1;
          mstate <= M_END;
        end
        M_READ:
        begin
          BUS.output_enable_n <= 1'b0;
          mcnt <= mcnt + 4'h1;
          if (mcnt == 4'(MUX_READ_CYC))
          begin
            MUX_RDATA <= BUS.data_pins;
            BUS.output_enable_n <= 1'b1;
            mstate <= M_END;
          end
        end
        M_RESET:
        begin
          BUS.interface_reset_n <= 1'b0;
          mcnt <= mcnt + 4'h1;
          if (mcnt == 4'(RESET_PULSE_MIN_CYC))
          begin
            BUS.interface_reset_n <= 1'b1;
            mstate <= M_END;
          end
        end
        M_END:
        begin
          BUS.dq_h_oe <= 1'b0;
          MUX_DONE <= 1'b1;
          mstate <= M_IDLE;
        end
        default:
        begin
          mstate <= M_IDLE;
        end
      endcase
    end
  end
endmodule // flash_port_host
`default_nettype wire

// file: flash_port_assertions.sv
// Checker for the pins between the flash host end and the flash device end.
`default_nettype none
module flash_port_assertions
  (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // LPC pins.
    input wire logic lframe_n,
    input wire logic [3:0] lad_h,
    input wire logic lad_h_oe,
    input wire logic [3:0] lad_d,
    input wire logic lad_d_oe,
    // Multiplexed port pins.
    input wire logic mux_mode,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic interface_reset_n,
    input wire logic dq_d_oe
  );
  timeunit 1ns;
  timeprecision 1ps;
  // Every check runs on the one clock and rests while reset is high.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // Turning the LAD drivers on must be fourteen edges after the frame start.
  a_frame_age: assert property ($rose(lad_d_oe) |-> !$past(lframe_n, 14))
    else $error("LAD drive began at the wrong distance from the frame start.");
  a_sync_nibble: assert property ($rose(lad_d_oe) |-> lad_d == 4'h0)
    else $error("Device drive began without the acknowledge nibble.");
  a_host_tar: assert property ($rose(lad_d_oe) |-> $past(lad_h_oe, 2) && $past(lad_h, 2) == 4'hf)
    else $error("Host skipped its ones nibble before letting go.");
  a_host_off: assert property ($rose(lad_d_oe) |-> !lad_h_oe && !$past(lad_h_oe))
    else $error("Host still drove LAD when the device took over.");
  a_tar_out: assert property (lad_d_oe && lad_d == 4'h0 && lframe_n |=> lad_d_oe && lad_d == 4'hf)
    else $error("Acknowledge was not followed by the ones nibble.");
  a_lad_release: assert property (lad_d_oe && lad_d == 4'hf |=> !lad_d_oe)
    else $error("Device kept LAD after its turnaround.");
  a_abort_release: assert property (lad_d_oe && !lframe_n |=> !lad_d_oe)
    else $error("Device kept LAD after the frame was pulled low.");
  a_dq_float: assert property (output_enable_n |=> !dq_d_oe)
    else $error("Data pins driven while output enable was high.");
  a_reset_float: assert property (!interface_reset_n |=> !lad_d_oe && !dq_d_oe)
    else $error("Device drove a pin during interface reset.");
  a_read_drive: assert property (mux_mode && !output_enable_n && write_enable_n && interface_reset_n
    |=> dq_d_oe)
    else $error("Device did not drive the data pins for a read.");
endmodule // flash_port_assertions
`default_nettype wire

// file: tb_top.sv
// Self-checking bench joining the flash host end to the flash device end.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_port_pkg::*;
  logic clk, rst, busy, sig_mode, mux_mode, lpc_req, mux_req, cap;
  logic lpc_ready, lpc_done, lpc_sync_ok, mux_ready, mux_done;
  logic cmd_valid, cmd_array, cmd_via_mux, in_reset, abort_op, prot, extra, cmd_valid2, cmd_array2;
  logic [31:0] lpc_addr, cmd_addr, cmd_addr2;
  logic [7:0] lpc_data, mux_wdata, mux_rdata, rd_data, cmd_data, cmd_data2;
  logic [1:0] mux_op;
  logic [20:0] mux_addr, rd_addr;
  logic [3:0] q[$];
  int n_mismatch, n_compared, n_cmd, n_cmd2, n_abort, n_rst;
  flash_port_if bus_if();
  flash_port_if bus2_if();
  // The array answers a byte made from its address, so a wrong address shows.
  assign rd_data = rd_addr[7:0] ^ rd_addr[20:13];
  flash_port_device flash_port_device_i (.CLK(clk), .RST(rst), .BUS(bus_if), .BUSY(busy),
    .SIG_MODE(sig_mode), .RD_DATA(rd_data), .RD_ADDR(rd_addr), .CMD_VALID(cmd_valid),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_ARRAY(cmd_array), .CMD_VIA_MUX(cmd_via_mux),
    .IN_RESET(in_reset), .ABORT_OP(abort_op), .PROTECT_ALLOWED(prot), .EXTRA_REGS_ALLOWED(extra));
  // The second device faces the bench, which breaks framing on purpose.
  flash_port_device flash_port_device_i_2 (.CLK(clk), .RST(rst), .BUS(bus2_if), .BUSY(busy),
    .SIG_MODE(sig_mode), .RD_DATA(rd_data), .RD_ADDR(), .CMD_VALID(cmd_valid2),
    .CMD_ADDR(cmd_addr2), .CMD_DATA(cmd_data2), .CMD_ARRAY(cmd_array2), .CMD_VIA_MUX(),
    .IN_RESET(), .ABORT_OP(), .PROTECT_ALLOWED(), .EXTRA_REGS_ALLOWED());
  flash_port_host flash_port_host_i (.CLK(clk), .RST(rst), .BUS(bus_if), .MUX_MODE(mux_mode),
    .LPC_REQ(lpc_req), .LPC_ADDR(lpc_addr), .LPC_DATA(lpc_data), .LPC_READY(lpc_ready),
    .LPC_DONE(lpc_done), .LPC_SYNC_OK(lpc_sync_ok), .MUX_REQ(mux_req), .MUX_OP(mux_op),
    .MUX_ADDR(mux_addr), .MUX_WDATA(mux_wdata), .MUX_READY(mux_ready), .MUX_DONE(mux_done),
    .MUX_RDATA(mux_rdata));
  flash_port_assertions flash_port_assertions_i (.CLK(clk), .RST(rst),
    .lframe_n(bus_if.lframe_n), .lad_h(bus_if.lad_h), .lad_h_oe(bus_if.lad_h_oe),
    .lad_d(bus_if.lad_d), .lad_d_oe(bus_if.lad_d_oe), .mux_mode(bus_if.mux_mode),
    .write_enable_n(bus_if.write_enable_n), .output_enable_n(bus_if.output_enable_n),
    .interface_reset_n(bus_if.interface_reset_n), .dq_d_oe(bus_if.dq_d_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 25 ns.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulse counters and the LAD capture of the first link.
  always @(posedge clk)
  begin
    n_cmd <= n_cmd + int'(cmd_valid);
    n_cmd2 <= n_cmd2 + int'(cmd_valid2);
    n_abort <= n_abort + int'(abort_op);
    n_rst <= n_rst + int'(in_reset);
    if (cap) q.push_back(bus_if.lad);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait; a flag that never rises counts as a mismatch.
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    check("handshake", s, 1'b1);
  endtask
  // One host write; every nibble on the wire is compared with the frame layout.
  task automatic t_lpc(input logic [31:0] a, input logic [7:0] d);
    logic [3:0] e[17];
    wait_hi(lpc_ready, 8);
    q.delete();
    lpc_addr = a;
    lpc_data = d;
    lpc_req = 1'b1;
    cap = 1'b1;
    @(negedge clk);
    lpc_req = 1'b0;
    wait_hi(lpc_done, 24);
    @(negedge clk);
    cap = 1'b0;
    check("sync ok", lpc_sync_ok, 1'b1);
    e[0] = 4'h0;
    e[1] = CYCTYPE_MEM_WRITE;
    for (int k = 0; k < 8; k++) e[2+k] = a[31-4*k -: 4];
    e[10] = d[3:0];
    e[11] = d[7:4];
    e[12] = 4'hf;
    e[13] = 4'hf;
    e[14] = 4'h0;
    e[15] = 4'hf;
    e[16] = 4'hf;
    for (int k = 0; k < 17; k++) check("lad", q[k+1], e[k]);
    check("cmd addr", cmd_addr, a);
    check("cmd data", cmd_data, d);
    check("cmd array", cmd_array, a[22]);
    check("via mux", cmd_via_mux, 1'b0);
    $display("test lpc write ended");
  endtask
  // Bench-driven frame on the second link, optionally cut short by the frame line.
  task automatic t_raw(input logic [3:0] cyc, input logic [31:0] a, input int cut, input logic ok);
    logic [3:0] n[13];
    logic seen;
    int c;
    seen = 1'b0;
    c = n_cmd2;
    n[0] = 4'h0;
    n[1] = cyc;
    for (int k = 0; k < 8; k++) n[2+k] = a[31-4*k -: 4];
    n[10] = 4'h3;
    n[11] = 4'hc;
    n[12] = 4'hf;
    for (int k = 0; k < 20; k++)
    begin
      @(negedge clk);
      if (bus2_if.lad_d_oe === 1'b1 && bus2_if.lad === 4'h0) seen = 1'b1;
      if (k == cut + 1) check("abort release", bus2_if.lad_d_oe, 1'b0);
      bus2_if.lframe_n = !(k == 0 || k == cut);
      bus2_if.lad_h_oe = (k < 13);
      bus2_if.lad_h = (k < 13 && k != cut) ? n[k] : 4'hf;
    end
    check("sync seen", seen, ok);
    check("cmd count", n_cmd2 - c, ok);
    if (ok) check("cmd data", cmd_data2, 8'hc3);
    if (ok) check("cmd array", cmd_array2, a[22]);
    $display("test framing ended");
  endtask
  task automatic t_mux(input logic [1:0] op, input logic [20:0] a, input logic [7:0] d);
    wait_hi(mux_ready, 8);
    mux_op = op;
    mux_addr = a;
    mux_wdata = d;
    mux_req = 1'b1;
    @(negedge clk);
    mux_req = 1'b0;
    wait_hi(mux_done, 40);
  endtask
  // Mux write, then reads of both signature codes, a plain byte and a far address.
  task automatic t_mux_rw;
    logic [20:0] ad[5];
    logic [7:0] x;
    int c;
    ad = '{21'h0, 21'h1, 21'h2, 21'h1a5c3, 21'h0};
    mux_mode = 1'b1;
    c = n_cmd;
    t_mux(MUX_OP_WRITE, 21'h1abcd, 8'h3c);
    @(negedge clk);
    check("mux cmd count", n_cmd - c, 1);
    check("mux cmd data", cmd_data, 8'h3c);
    check("mux cmd addr", cmd_addr[20:0], 21'h1abcd);
    check("mux flags", {cmd_via_mux, cmd_array, prot, extra}, 4'hc);
    for (int i = 0; i < 5; i++)
    begin
      sig_mode = (i < 4);
      x = ad[i][7:0] ^ ad[i][20:13];
      if (sig_mode && ad[i][20:1] == 20'h0) x = ad[i][0] ? 8'ha5 : 8'h5a;
      t_mux(MUX_OP_READ, ad[i], 8'h00);
      check("read addr", rd_addr, ad[i]);
      check("read data", mux_rdata, x);
      @(negedge clk);
      check("pins floating", bus_if.data_pins, 8'hff);
    end
    $display("test mux read write ended");
  endtask
  // Interface reset during a busy program aborts it.
  task automatic t_reset;
    int c, r;
    busy = 1'b1;
    c = n_abort;
    r = n_rst;
    t_mux(MUX_OP_RESET, 21'h0, 8'h00);
    repeat (2) @(negedge clk);
    check("abort count", n_abort - c, 1);
    check("reset cycles", n_rst - r, RESET_PULSE_MIN_CYC);
    check("latches cleared", rd_addr, 21'h0);
    busy = 1'b0;
    $display("test reset ended");
  endtask
  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the second link's host pins are driven by the bench.
  initial
  begin
    {rst, busy, sig_mode, mux_mode, lpc_req, mux_req, cap} = 7'h40;
    {lpc_addr, lpc_data, mux_wdata, mux_op, mux_addr} = '0;
    {bus2_if.lframe_n, bus2_if.lad_h, bus2_if.lad_h_oe} = 6'h3e;
    {bus2_if.mux_mode, bus2_if.mux_address_inputs, bus2_if.row_column_select} = 13'h0000;
    {bus2_if.write_enable_n, bus2_if.output_enable_n, bus2_if.interface_reset_n} = 3'h7;
    {bus2_if.dq_h, bus2_if.dq_h_oe} = 9'h000;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_lpc(32'hffc0_1234, 8'ha7);
    t_lpc(32'hff80_5678, 8'h5e);
    t_raw(4'h7, 32'hffbf_0012, 99, 1'b1);
    t_raw(4'h4, 32'hffff_0012, 99, 1'b0);
    t_raw(4'h6, 32'hfbff_0012, 99, 1'b0);
    t_raw(4'h6, 32'hffff_0012, 5, 1'b0);
    t_raw(4'h6, 32'hffbf_0012, 14, 1'b1);
    t_mux_rw;
    t_reset;
    print_verdict;
  end
  // Watchdog far beyond what the sequence needs.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
